// >>> fapa_consts.svh
// fapa_consts.svh: addresses, field positions, reset values and codes of the flash access block.
// assumes an 8-bit special-register bus and a 16-bit flash address space.
`ifndef FAPA_CONSTS_SVH
`define FAPA_CONSTS_SVH

// special-register addresses on the processor bus
`define FAPA_ADDR_DATA_PORT    8'hE2
`define FAPA_ADDR_ADDR_HIGH    8'hE3
`define FAPA_ADDR_ADDR_LOW     8'hE4
`define FAPA_ADDR_MODE_SELECT  8'hE5
`define FAPA_ADDR_KEY_PORT     8'hE6
`define FAPA_ADDR_CTRL_STATUS  8'hF7
`define FAPA_ADDR_TIMEBASE     8'hBF

// protected page index of the update-region low bound
`define FAPA_PP_LOW_BOUND      8'h03

// control/status bit positions
`define FAPA_BIT_ENABLE        7
`define FAPA_BIT_BOOT_SEL      6
`define FAPA_BIT_SOFT_RESET    5
`define FAPA_BIT_FAIL          4

// timebase register bit positions
`define FAPA_BIT_XTAL_READY    7

// key sequence bytes
`define FAPA_KEY_FIRST         8'h46
`define FAPA_KEY_SECOND        8'hB9

// reset values
`define FAPA_RST_DATA_PORT     8'hFF
`define FAPA_RST_ADDR          8'h00
`define FAPA_RST_MODE          4'h0
`define FAPA_RST_CTRL          4'h0
`define FAPA_RST_TIMEBASE      6'h0B
`define FAPA_RST_LOW_BOUND     8'h36

// first address of the boot region; update region ends one below it
`define FAPA_BOOT_START        16'h3A00

`endif

// >>> fapa_pkg.sv
// fapa_pkg: types shared by the flash access block.
// assumes fapa_consts.svh is available for the numeric constants.
package fapa_pkg;

   typedef enum logic [3:0] {
      FAPA_MODE_STANDBY = 4'b0000,
      FAPA_MODE_READ    = 4'b0001,
      FAPA_MODE_PROGRAM = 4'b0010,
      FAPA_MODE_ERASE   = 4'b0011,
      FAPA_MODE_PP_WR   = 4'b0100,
      FAPA_MODE_PP_RD   = 4'b0101
   } fapa_mode_t;

   typedef enum logic [1:0] {
      FAPA_FL_READ    = 2'b01,
      FAPA_FL_PROGRAM = 2'b10,
      FAPA_FL_ERASE   = 2'b11
   } fapa_fl_cmd_t;

   typedef enum logic [1:0] {
      FAPA_ST_IDLE  = 2'b00,
      FAPA_ST_FLASH = 2'b01,
      FAPA_ST_PAGE  = 2'b10
   } fapa_state_t;

   typedef enum logic {
      FAPA_KEY_IDLE = 1'b0,
      FAPA_KEY_ARMED = 1'b1
   } fapa_key_state_t;

endpackage : fapa_pkg

// >>> fapa_key_seq.sv
// fapa_key_seq: watches writes to the command key port for the two-byte start sequence.
// assumes writes arrive as single-cycle strobes on the system clock, reset already synchronised.
`include "fapa_consts.svh"

module fapa_key_seq
   import fapa_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_key_wr,
   input  wire logic [7:0] i_key_data,
   output logic            o_trigger
);

   fapa_key_state_t state;
   fapa_key_state_t next_state;

   // trigger is combinational so the stall can begin on the edge of the second write
   always_comb begin
      next_state = state;
      o_trigger  = 1'b0;
      if (i_key_wr) begin
         if (state == FAPA_KEY_ARMED && i_key_data == `FAPA_KEY_SECOND) begin
            o_trigger  = 1'b1;  // see RQ18
            next_state = FAPA_KEY_IDLE;
         end else if (i_key_data == `FAPA_KEY_FIRST) begin
            next_state = FAPA_KEY_ARMED;
         end else begin
            next_state = FAPA_KEY_IDLE;  // see RQ21
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= FAPA_KEY_IDLE;
      end else begin
         state <= next_state;
      end
   end

endmodule : fapa_key_seq

// >>> fapa_top.sv
// fapa_top: flash read/program/erase sequencer and protected page access behind special registers.
// assumes a single-cycle register bus from the core and a flash macro that pulses done.
`include "fapa_consts.svh"

// Operation
// RQ1 - enable bit low refuses all operations
// RQ2 - boot select bit chooses reset boot memory
// RQ3 - soft reset bit pulses reset, self-clears
// RQ4 - fail flag reports last command outcome
// RQ5 - software writes zeros to reserved bits
// RQ6 - software loads timebase as MHz minus one
// RQ7 - timebase field resets to twelve MHz value
// RQ8 - software writes only even low bounds
// RQ9 - update region spans bound*256 to boot-1
// RQ10 - software keeps low bound below boot
// RQ11 - protected access uses high address zero
// RQ12 - mode 04h writes data into protected page
// RQ13 - mode 05h reads protected page into data
// RQ14 - software sets up, then writes key pair
// RQ15 - software loads data before protected write
// RQ16 - core stalled from key until done
// RQ17 - modes 01/02/03 read, program, erase
// RQ18 - start only on key pair while enabled
// RQ19 - out-of-region update from application ignored
// RQ20 - page erase ignores low address byte
// RQ21 - wrong second key byte discards sequence
// RQ22 - failed update sets flag, success clears
module fapa_top
   import fapa_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_arst_n,
   input  wire logic [7:0]  i_sfr_addr,
   input  wire logic        i_sfr_wr,
   input  wire logic        i_sfr_rd,
   input  wire logic [7:0]  i_sfr_wdata,
   output logic      [7:0]  o_sfr_rdata,
   input  wire logic        i_exec_in_ap,
   input  wire logic        i_crystal_ready,
   output logic             o_cpu_stall,
   output logic             o_soft_reset,
   output logic             o_boot_from_isp,
   output logic      [5:0]  o_timebase_mhz,
   output logic             o_fl_req,
   output logic      [1:0]  o_fl_cmd,
   output logic      [15:0] o_fl_addr,
   output logic      [7:0]  o_fl_wdata,
   input  wire logic        i_fl_done,
   input  wire logic [7:0]  i_fl_rdata
);

   logic        rst_meta;
   logic        rst_n;
   logic        xtal_meta;
   logic        xtal_sync;
   logic        trigger;

   fapa_state_t state;
   fapa_state_t next_state;
   logic [7:0]  data_port;
   logic [7:0]  next_data_port;
   logic [7:0]  addr_high;
   logic [7:0]  next_addr_high;
   logic [7:0]  addr_low;
   logic [7:0]  next_addr_low;
   logic [3:0]  mode_sel;
   logic [3:0]  next_mode_sel;
   logic        access_en;
   logic        next_access_en;
   logic        boot_sel;
   logic        next_boot_sel;
   logic        fail_flag;
   logic        next_fail_flag;
   logic        soft_reset;
   logic        next_soft_reset;
   logic [5:0]  timebase;
   logic [5:0]  next_timebase;
   logic [7:0]  low_bound;
   logic [7:0]  next_low_bound;
   logic [7:0]  rdata;
   logic [7:0]  next_rdata;
   logic        stall;
   logic        next_stall;
   logic        fl_req;
   logic        next_fl_req;
   logic [1:0]  fl_cmd;
   logic [1:0]  next_fl_cmd;
   logic [15:0] fl_addr;
   logic [15:0] next_fl_addr;
   logic [7:0]  fl_wdata;
   logic [7:0]  next_fl_wdata;

   logic [15:0] target;
   logic [15:0] region_low;
   logic        in_region;
   logic        wr_hit_ctrl;

   // reset release and crystal-ready level both cross in through two flops
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         xtal_meta <= 1'b0;
         xtal_sync <= 1'b0;
      end else begin
         xtal_meta <= i_crystal_ready;
         xtal_sync <= xtal_meta;
      end
   end

   fapa_key_seq fapa_key_seq_i (
      .i_clk      (i_clk),
      .i_rst_n    (rst_n),
      .i_key_wr   (i_sfr_wr && i_sfr_addr == `FAPA_ADDR_KEY_PORT),
      .i_key_data (i_sfr_wdata),
      .o_trigger  (trigger)
   );

   // erase selects the page by the high byte only
   assign target      = (mode_sel == FAPA_MODE_ERASE) ? {addr_high, 8'h00}
                                                      : {addr_high, addr_low};  // see RQ20
   assign region_low  = {low_bound, 8'h00};  // see RQ9
   // code running from the boot region may update any location
   assign in_region   = !i_exec_in_ap ||
                        (target >= region_low && target < `FAPA_BOOT_START);  // see RQ9
   assign wr_hit_ctrl = i_sfr_wr && i_sfr_addr == `FAPA_ADDR_CTRL_STATUS;

   always_comb begin
      next_state      = state;
      next_data_port  = data_port;
      next_addr_high  = addr_high;
      next_addr_low   = addr_low;
      next_mode_sel   = mode_sel;
      next_access_en  = access_en;
      next_boot_sel   = boot_sel;
      next_fail_flag  = fail_flag;
      next_soft_reset = 1'b0;
      next_timebase   = timebase;
      next_low_bound  = low_bound;
      next_rdata      = rdata;
      next_stall      = stall;
      next_fl_req     = 1'b0;
      next_fl_cmd     = fl_cmd;
      next_fl_addr    = fl_addr;
      next_fl_wdata   = fl_wdata;

      // software writes; reserved bits are simply not stored
      if (i_sfr_wr) begin
         if (i_sfr_addr == `FAPA_ADDR_DATA_PORT) begin
            next_data_port = i_sfr_wdata;
         end else if (i_sfr_addr == `FAPA_ADDR_ADDR_HIGH) begin
            next_addr_high = i_sfr_wdata;
         end else if (i_sfr_addr == `FAPA_ADDR_ADDR_LOW) begin
            next_addr_low = i_sfr_wdata;
         end else if (i_sfr_addr == `FAPA_ADDR_MODE_SELECT) begin
            next_mode_sel = i_sfr_wdata[3:0];
         end else if (i_sfr_addr == `FAPA_ADDR_TIMEBASE) begin
            next_timebase = i_sfr_wdata[5:0];
         end else if (wr_hit_ctrl) begin
            next_access_en  = i_sfr_wdata[`FAPA_BIT_ENABLE];
            next_boot_sel   = i_sfr_wdata[`FAPA_BIT_BOOT_SEL];  // see RQ2
            next_fail_flag  = i_sfr_wdata[`FAPA_BIT_FAIL];
            next_soft_reset = i_sfr_wdata[`FAPA_BIT_SOFT_RESET];  // see RQ3
         end
      end

      // command outcome is applied after the bus write so hardware wins the flag
      case (state)
         FAPA_ST_IDLE: begin
            if (trigger) begin
               if (!access_en) begin
                  next_fail_flag = 1'b1;  // see RQ1
               end else if (mode_sel == FAPA_MODE_READ) begin
                  next_fl_cmd  = FAPA_FL_READ;  // see RQ17
                  next_fl_addr = target;
                  next_fl_req  = 1'b1;
                  next_stall   = 1'b1;  // see RQ16
                  next_state   = FAPA_ST_FLASH;
               end else if (mode_sel == FAPA_MODE_PROGRAM || mode_sel == FAPA_MODE_ERASE) begin
                  if (in_region) begin
                     next_fl_cmd   = (mode_sel == FAPA_MODE_ERASE) ? FAPA_FL_ERASE
                                                                   : FAPA_FL_PROGRAM;  // see RQ17
                     next_fl_addr  = target;
                     next_fl_wdata = data_port;
                     next_fl_req   = 1'b1;
                     next_stall    = 1'b1;  // see RQ16
                     next_state    = FAPA_ST_FLASH;
                  end else begin
                     next_fail_flag = 1'b1;  // see RQ19 see RQ22
                  end
               end else if (mode_sel == FAPA_MODE_PP_WR || mode_sel == FAPA_MODE_PP_RD) begin
                  next_stall = 1'b1;  // see RQ16
                  next_state = FAPA_ST_PAGE;
               end else begin
                  next_fail_flag = 1'b1;
               end
            end
         end
         FAPA_ST_FLASH: begin
            if (i_fl_done) begin
               if (fl_cmd == FAPA_FL_READ) begin
                  next_data_port = i_fl_rdata;
               end
               next_fail_flag = 1'b0;  // see RQ4 see RQ22
               next_stall     = 1'b0;
               next_state     = FAPA_ST_IDLE;
            end
         end
         FAPA_ST_PAGE: begin
            // only the low bound lives here; other indices read zero, writes drop
            if (mode_sel == FAPA_MODE_PP_WR) begin
               if (addr_low == `FAPA_PP_LOW_BOUND) begin
                  next_low_bound = data_port;  // see RQ12
               end
            end else begin
               next_data_port = (addr_low == `FAPA_PP_LOW_BOUND) ? low_bound : 8'h00;  // see RQ13
            end
            next_fail_flag = 1'b0;  // see RQ4
            next_stall     = 1'b0;
            next_state     = FAPA_ST_IDLE;
         end
         default: begin
            next_state = FAPA_ST_IDLE;
         end
      endcase

      if (i_sfr_rd) begin
         if (i_sfr_addr == `FAPA_ADDR_DATA_PORT) begin
            next_rdata = data_port;
         end else if (i_sfr_addr == `FAPA_ADDR_ADDR_HIGH) begin
            next_rdata = addr_high;
         end else if (i_sfr_addr == `FAPA_ADDR_ADDR_LOW) begin
            next_rdata = addr_low;
         end else if (i_sfr_addr == `FAPA_ADDR_MODE_SELECT) begin
            next_rdata = {4'h0, mode_sel};
         end else if (i_sfr_addr == `FAPA_ADDR_TIMEBASE) begin
            next_rdata = {xtal_sync, 1'b0, timebase};
         end else if (i_sfr_addr == `FAPA_ADDR_CTRL_STATUS) begin
            // soft reset bit always reads back zero
            next_rdata = {access_en, boot_sel, 1'b0, fail_flag, 4'h0};  // see RQ3
         end else begin
            next_rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state      <= FAPA_ST_IDLE;
         data_port  <= `FAPA_RST_DATA_PORT;
         addr_high  <= `FAPA_RST_ADDR;
         addr_low   <= `FAPA_RST_ADDR;
         mode_sel   <= `FAPA_RST_MODE;
         access_en  <= 1'b0;
         boot_sel   <= 1'b0;
         fail_flag  <= 1'b0;
         soft_reset <= 1'b0;
         timebase   <= `FAPA_RST_TIMEBASE;  // see RQ7
         low_bound  <= `FAPA_RST_LOW_BOUND;
         rdata      <= 8'h00;
         stall      <= 1'b0;
         fl_req     <= 1'b0;
         fl_cmd     <= FAPA_FL_READ;
         fl_addr    <= 16'h0000;
         fl_wdata   <= 8'h00;
      end else begin
         state      <= next_state;
         data_port  <= next_data_port;
         addr_high  <= next_addr_high;
         addr_low   <= next_addr_low;
         mode_sel   <= next_mode_sel;
         access_en  <= next_access_en;
         boot_sel   <= next_boot_sel;
         fail_flag  <= next_fail_flag;
         soft_reset <= next_soft_reset;
         timebase   <= next_timebase;
         low_bound  <= next_low_bound;
         rdata      <= next_rdata;
         stall      <= next_stall;
         fl_req     <= next_fl_req;
         fl_cmd     <= next_fl_cmd;
         fl_addr    <= next_fl_addr;
         fl_wdata   <= next_fl_wdata;
      end
   end

   assign o_sfr_rdata     = rdata;
   assign o_cpu_stall     = stall;
   assign o_soft_reset    = soft_reset;
   assign o_boot_from_isp = boot_sel;
   assign o_timebase_mhz  = timebase;
   assign o_fl_req        = fl_req;
   assign o_fl_cmd        = fl_cmd;
   assign o_fl_addr       = fl_addr;
   assign o_fl_wdata      = fl_wdata;

endmodule : fapa_top

// >>> fapa_props.sv
// fapa_props: timing relations at the ports of fapa_top.
// assumes it is bound to fapa_top and sees only its ports.
module fapa_props (
   input wire logic        i_clk,
   input wire logic        i_arst_n,
   input wire logic [7:0]  i_sfr_addr,
   input wire logic        i_sfr_wr,
   input wire logic        i_sfr_rd,
   input wire logic [7:0]  i_sfr_wdata,
   input wire logic [7:0]  o_sfr_rdata,
   input wire logic        o_cpu_stall,
   input wire logic        o_soft_reset,
   input wire logic        o_fl_req,
   input wire logic [1:0]  o_fl_cmd,
   input wire logic [15:0] o_fl_addr,
   input wire logic        i_fl_done
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);
   a_ctrl_resv_zero: assert property (
      i_sfr_rd && i_sfr_addr == 8'hF7 |=> o_sfr_rdata[5] == 1'b0 && o_sfr_rdata[3:0] == 4'h0)
      else $error("control read shows reserved or trigger bits");
   a_soft_rst_pulse: assert property (o_soft_reset |=> !o_soft_reset)
      else $error("soft reset longer than one cycle");
   a_soft_rst_cause: assert property (
      $rose(o_soft_reset) |-> $past(i_sfr_wr && i_sfr_addr == 8'hF7 && i_sfr_wdata[5]))
      else $error("soft reset without a write of one");
   a_stall_from_key: assert property (
      $rose(o_cpu_stall) |-> $past(i_sfr_wr && i_sfr_addr == 8'hE6 && i_sfr_wdata == 8'hB9))
      else $error("stall without second key byte");
   a_req_with_stall: assert property (o_fl_req |-> $rose(o_cpu_stall))
      else $error("flash request not at stall start");
   a_req_single: assert property (o_fl_req |=> !o_fl_req)
      else $error("flash request longer than one cycle");
   a_done_ends_stall: assert property (i_fl_done && o_cpu_stall |=> !o_cpu_stall)
      else $error("stall held after flash done");
   a_page_stall_one: assert property (
      $rose(o_cpu_stall) && !o_fl_req |=> !o_cpu_stall)
      else $error("page access stall not one cycle");
   a_erase_low_zero: assert property (
      o_fl_req && o_fl_cmd == 2'b11 |-> o_fl_addr[7:0] == 8'h00)
      else $error("erase address low byte not zero");
endmodule : fapa_props

// >>> fapa_flash_model.sv
// fapa_flash_model: behavioural flash array answering fapa_top requests.
// assumes one clock; erased cells read ff, program only clears bits.
module fapa_flash_model (
   input wire logic        i_clk,
   input wire logic        i_slow,
   input wire logic        i_req,
   input wire logic [1:0]  i_cmd,
   input wire logic [15:0] i_addr,
   input wire logic [7:0]  i_wdata,
   output logic            o_done,
   output logic [7:0]      o_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  mem [int];
   logic [1:0]  cmd;
   logic [15:0] ad;
   logic [7:0]  wd;
   int          cnt = 0;
   initial begin
      o_done = 1'b0;
      o_rdata = 8'h5A;
   end
   // read data toggles outside the done cycle so stale values never pass
   always @(posedge i_clk) begin
      o_done <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_req) begin
         cmd <= i_cmd;
         ad <= i_addr;
         wd <= i_wdata;
         cnt <= i_slow ? 12 : 2;
      end else if (cnt == 1) begin
         cnt <= 0;
         o_done <= 1'b1;
         if (cmd == 2'b01) o_rdata <= mem.exists(ad) ? mem[ad] : 8'hFF;
         if (cmd == 2'b10) mem[ad] = (mem.exists(ad) ? mem[ad] : 8'hFF) & wd;
         if (cmd == 2'b11) for (int k = 0; k < 512; k++) mem.delete({ad[15:9], 9'h000} + k);
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule : fapa_flash_model

// >>> fapa_tb.sv
// fapa_tb: self-checking bench for fapa_top with a flash model.
// assumes the register bus strobes last one cycle, driven at falling edges.
module fapa_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, w, r, ap, xr, stall, srst, boot, req, done, slow, en, bt;
   logic [7:0] a, wd, rdat, frd, fwd, q, d, ah, al, lb;
   logic [5:0] tbm;
   logic [1:0] cmd;
   logic [15:0] fa;
   logic [6:0] pg;
   int fails = 0;
   int comparisons = 0;
   fapa_top fapa_top_i (.i_clk(clk), .i_arst_n(rst_n), .i_sfr_addr(a), .i_sfr_wr(w),
      .i_sfr_rd(r), .i_sfr_wdata(wd), .o_sfr_rdata(rdat), .i_exec_in_ap(ap),
      .i_crystal_ready(xr), .o_cpu_stall(stall), .o_soft_reset(srst), .o_boot_from_isp(boot),
      .o_timebase_mhz(tbm), .o_fl_req(req), .o_fl_cmd(cmd), .o_fl_addr(fa), .o_fl_wdata(fwd),
      .i_fl_done(done), .i_fl_rdata(frd));
   fapa_flash_model fapa_flash_model_i (.i_clk(clk), .i_slow(slow), .i_req(req), .i_cmd(cmd),
      .i_addr(fa), .i_wdata(fwd), .o_done(done), .o_rdata(frd));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic tally_and_finish();
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish
   initial begin
      #1_000_000;
      fails++;
      tally_and_finish();
   end
   task automatic chk(input logic [7:0] g, e);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] ad, dt);
      @(negedge clk);
      a = ad;
      wd = dt;
      w = 1'b1;
      @(negedge clk);
      w = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] ad);
      @(negedge clk);
      a = ad;
      r = 1'b1;
      @(negedge clk);
      r = 1'b0;
      q = rdat;
   endtask : rd
   task automatic ckf(input logic f);
      rd(8'hF7);
      chk(q, {en, bt, 1'b0, f, 4'h0});
   endtask : ckf
   task automatic op(input logic [3:0] m, input logic [7:0] h, l, input logic go);
      int i;
      logic s;
      s = 1'b0;
      wr(8'hE3, h);
      wr(8'hE4, l);
      wr(8'hE5, {4'h0, m});
      wr(8'hE6, 8'h46);
      wr(8'hE6, 8'hB9);
      // a page access stalls for one cycle only, so look before the first wait
      for (i = 0; i < 40; i++) begin
         if (stall === 1'b1) s = 1'b1;
         else if (s || i > 2) break;
         @(negedge clk);
      end
      chk(8'(s), 8'(go));
      if (i == 40) begin
         fails++;
         tally_and_finish();
      end
   endtask : op
   initial begin
      {a, wd, w, r, ap, xr, slow, en, bt, rst_n} = '0;
      ap = 1'b1;
      xr = 1'b1;
      lb = 8'h36;
      void'($urandom(32'h7042));
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      rd(8'hBF);
      chk(q, 8'h8B);
      chk(8'(tbm), 8'h0B);
      rd(8'hE2);
      chk(q, 8'hFF);
      op(4'h1, 8'h36, 8'h00, 1'b0);
      ckf(1'b1);
      en = 1'b1;
      wr(8'hF7, 8'h80);
      op(4'h5, 8'h00, 8'h03, 1'b1);
      rd(8'hE2);
      chk(q, lb);
      lb = 8'h34;
      wr(8'hE2, lb);
      op(4'h4, 8'h00, 8'h03, 1'b1);
      wr(8'hE2, 8'h00);
      op(4'h5, 8'h00, 8'h03, 1'b1);
      rd(8'hE2);
      chk(q, lb);
      ckf(1'b0);
      bt = 1'b1;
      wr(8'hF7, 8'hC0);
      @(negedge clk);
      chk(8'(boot), 8'h01);
      bt = 1'b0;
      wr(8'hF7, 8'hA0);
      chk(8'(srst), 8'h01);
      ckf(1'b0);
      for (int k = 0; k < 6; k++) begin
         pg = (k == 0) ? 7'(lb >> 1) : 7'((lb >> 1) + $urandom % (29 - (lb >> 1)));
         ah = {pg, (k == 0) ? 1'b0 : 1'($urandom)};
         al = (k == 0) ? 8'h00 : 8'($urandom);
         d = 8'($urandom);
         slow = k[0];
         op(4'h3, {pg, 1'($urandom)}, 8'($urandom), 1'b1);
         wr(8'hE2, d);
         op(4'h2, ah, al, 1'b1);
         op(4'h1, ah, al, 1'b1);
         rd(8'hE2);
         chk(q, d);
         op(4'h1, ah, al ^ 8'h01, 1'b1);
         rd(8'hE2);
         chk(q, 8'hFF);
         ckf(1'b0);
      end
      op(4'h2, 8'h3A, 8'h10, 1'b0);
      ckf(1'b1);
      op(4'h3, lb - 8'h01, 8'hFF, 1'b0);
      ckf(1'b1);
      op(4'h1, 8'h3A, 8'h10, 1'b1);
      ckf(1'b0);
      ap = 1'b0;
      wr(8'hE2, 8'h00);
      op(4'h2, 8'h3A, 8'h10, 1'b1);
      ap = 1'b1;
      wr(8'hE2, 8'hEE);
      wr(8'hE6, 8'h46);
      wr(8'hE6, 8'h47);
      wr(8'hE6, 8'hB9);
      repeat (2) @(negedge clk);
      chk(8'(stall), 8'h00);
      ckf(1'b0);
      op(4'h1, 8'h3A, 8'h10, 1'b1);
      rd(8'hE2);
      chk(q, 8'h00);
      op(4'h6, 8'h00, 8'h00, 1'b0);
      ckf(1'b1);
      xr = 1'b0;
      wr(8'hBF, 8'h45);
      repeat (3) @(negedge clk);
      rd(8'hBF);
      chk(q, 8'h05);
      chk(8'(tbm), 8'h05);
      en = 1'b0;
      wr(8'hF7, 8'h00);
      op(4'h5, 8'h00, 8'h03, 1'b0);
      ckf(1'b1);
      tally_and_finish();
   end
endmodule : fapa_tb
bind fapa_top fapa_props fapa_props_i (.i_clk(i_clk), .i_arst_n(i_arst_n),
   .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
   .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .o_cpu_stall(o_cpu_stall),
   .o_soft_reset(o_soft_reset), .o_fl_req(o_fl_req), .o_fl_cmd(o_fl_cmd),
   .o_fl_addr(o_fl_addr), .i_fl_done(i_fl_done));
